// ---- bench/pba_checker.sv ----
// Assertions on the link between the core and application ends
`timescale 1ns/1ps
module pba_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic address_phase_strobe,
  input wire logic transfer_done_strobe,
  input wire logic source_advance_strobe,
  input wire logic ini_addr_phase,
  input wire logic tgt_read,
  input wire logic [pba_pkg::DATA_W-1:0] internal_shared_bus
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_adv;
    ##[0:2] source_advance_strobe;
  endsequence
  sequence s_quiet;
    !source_advance_strobe && !$past(source_advance_strobe) && tgt_read && $past(tgt_read);
  endsequence
  a_first_word: assert property (ini_addr_phase |-> s_adv) else $error("no first advance");
  a_xfer_advance: assert property (transfer_done_strobe && tgt_read |-> s_adv)
    else $error("no advance after transfer");
  a_word_held: assert property (s_quiet |-> $stable(internal_shared_bus))
    else $error("next word moved");
  a_adv_pulse: assert property (source_advance_strobe |=> !source_advance_strobe)
    else $error("advance not a pulse");
  a_addr_no_xfer: assert property (address_phase_strobe |-> !transfer_done_strobe)
    else $error("transfer in address phase");
  a_ini_no_xfer: assert property (ini_addr_phase |-> !transfer_done_strobe)
    else $error("transfer in initiator address");
  a_tgt_no_adv: assert property (address_phase_strobe |-> !source_advance_strobe)
    else $error("advance in target address");
  a_adv_cause: assert property (source_advance_strobe |-> transfer_done_strobe
    || $past(transfer_done_strobe) || ini_addr_phase || $past(ini_addr_phase)
    || $past(ini_addr_phase, 2) || $past(address_phase_strobe))
    else $error("advance without cause");
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench joining the core and application ends
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic irdy_n = 1'b1, trdy_n = 1'b1, tgt_addr_st = 1'b0, tgt_data_st = 1'b0;
  logic ini_addr_st = 1'b0, ini_data_st = 1'b0, tgt_is_read = 1'b0, ini_is_write = 1'b0;
  logic frame_end = 1'b0, ini_start = 1'b0, wr_en = 1'b0;
  logic [31:0] pci_ad_in = 32'h0, ini_start_addr = 32'h0, wr_data = 32'h0;
  logic [31:0] ad_out_q, tgt_addr_q, ini_addr_q;
  logic [7:0] term_status = 8'h00;
  logic [3:0] wr_idx = 4'h0, src_ptr_q;
  logic ready_out_q, term_out_q, ini_restart_q;
  logic destructive = 1'b0, stop_req = 1'b0, stop_with_data = 1'b0;
  logic [1:0] mode_q;
  int failures = 0;
  int n_compared = 0;
  pba_link_if link();
  pba_core i_pba_core (.sys_clk, .sys_rst, .link(link), .irdy_n, .trdy_n, .tgt_addr_st,
    .tgt_data_st, .ini_addr_st, .ini_data_st, .tgt_is_read, .ini_is_write, .frame_end,
    .pci_ad_in, .term_status, .csr_low(32'h0), .ad_out_q, .ready_out_q, .term_out_q);
  pba_app i_pba_app (.sys_clk, .sys_rst, .link(link), .ini_start, .ini_start_addr,
    .src_start_idx(4'h0), .destructive, .stop_req, .stop_with_data,
    .wr_en, .wr_idx, .wr_data, .tgt_addr_q, .ini_addr_q, .src_ptr_q, .ini_restart_q,
    .mode_q);
  pba_checker i_pba_checker (.sys_clk, .sys_rst,
    .address_phase_strobe(link.address_phase_strobe),
    .transfer_done_strobe(link.transfer_done_strobe),
    .source_advance_strobe(link.source_advance_strobe),
    .ini_addr_phase(link.ini_addr_phase), .tgt_read(link.tgt_read),
    .internal_shared_bus(link.internal_shared_bus));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // One burst: address phase, then n transfers with a wait between
  // ----------------------------------------------------------------
  task automatic burst(input logic ini, input logic rd, input logic [31:0] a, input int n);
    int k;
    @(posedge sys_clk);
    tgt_addr_st <= !ini;
    ini_addr_st <= ini;
    ini_start <= ini;
    pci_ad_in <= a;
    ini_start_addr <= a;
    tgt_is_read <= rd;
    ini_is_write <= ini;
    @(posedge sys_clk);
    tgt_addr_st <= 1'b0;
    ini_addr_st <= 1'b0;
    ini_start <= 1'b0;
    tgt_data_st <= !ini;
    ini_data_st <= ini;
    irdy_n <= 1'b0;
    // In a target read or initiator burst, the first word must be advanced before any transfer is offered
    for (k = 0; k < 8 && (ini || rd) && !link.source_advance_strobe; k++) @(posedge sys_clk);
    if (k == 8) begin
      failures++;
      summarize();
    end
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      trdy_n <= 1'b0;
      frame_end <= (i == n - 1);
      @(posedge sys_clk);
      trdy_n <= 1'b1;
    end
    frame_end <= 1'b0;
    tgt_data_st <= 1'b0;
    ini_data_st <= 1'b0;
    irdy_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_tgt_write();
    logic [31:0] a = 32'h1234_5FF8;
    burst(1'b0, 1'b0, a, 3);
    chk(tgt_addr_q, {a[31:12], a[11:0] + 12'h00C});
    chk({31'h0, term_out_q}, 32'h1);
    chk({30'h0, mode_q}, 32'h0);
    $display("t_tgt_write done");
  endtask
  task automatic t_tgt_read();
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      wr_en <= 1'b1;
      wr_idx <= i[3:0];
      wr_data <= 32'hA000_0000 + i;
    end
    @(posedge sys_clk);
    wr_en <= 1'b0;
    burst(1'b0, 1'b1, 32'h0000_0040, 4);
    chk({28'h0, src_ptr_q}, 32'h4);
    chk(ad_out_q, 32'hA000_0004);
    chk({31'h0, term_out_q}, 32'h0);
    $display("t_tgt_read done");
  endtask
  task automatic t_ini_term();
    logic [31:0] a = 32'h8000_0100;
    destructive <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      @(posedge sys_clk);
      term_status <= 8'h01 << c;
      burst(1'b1, 1'b0, a, 2);
      chk({24'h0, link.config_status_bus[39:32]}, {24'h0, 8'h01 << c});
      chk(ini_addr_q, (c == pba_pkg::TERM_RETRY) ? a : a + 32'h8);
      chk({28'h0, src_ptr_q}, (c == pba_pkg::TERM_RETRY) ? 32'h0 : 32'h2);
      chk({31'h0, ini_restart_q}, (c == pba_pkg::TERM_RETRY) ? 32'h1 : 32'h0);
      @(posedge sys_clk);
      term_status <= 8'h00;
    end
    destructive <= 1'b0;
    $display("t_ini_term done");
  endtask
  task automatic t_stop();
    @(posedge sys_clk);
    stop_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, ready_out_q}, 32'h0);
    chk({31'h0, term_out_q}, 32'h1);
    stop_with_data <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, ready_out_q}, 32'h1);
    stop_req <= 1'b0;
    stop_with_data <= 1'b0;
    repeat (3) @(posedge sys_clk);
    $display("t_stop done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_tgt_write();
    t_tgt_read();
    t_ini_term();
    t_stop();
    summarize();
  end
endmodule

// ---- verilog/pba_app.sv ----
// User application end: address tracking and pipelined data source
`timescale 1ns/1ps
module pba_app #(
  parameter int TGT_W = pba_pkg::TGT_CNT_W,
  parameter int INI_W = pba_pkg::INI_CNT_W,
  parameter int DEPTH = pba_pkg::SRC_DEPTH,
  parameter int IDX_W = pba_pkg::SRC_IDX_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  pba_link_if.app_mp link,
  input wire logic ini_start,
  input wire logic [pba_pkg::ADDR_W-1:0] ini_start_addr,
  input wire logic [IDX_W-1:0] src_start_idx,
  input wire logic destructive,
  input wire logic stop_req,
  input wire logic stop_with_data,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [pba_pkg::DATA_W-1:0] wr_data,
  output logic [pba_pkg::ADDR_W-1:0] tgt_addr_q,
  output logic [pba_pkg::ADDR_W-1:0] ini_addr_q,
  output logic [IDX_W-1:0] src_ptr_q,
  output logic ini_restart_q,
  output logic [1:0] mode_q
);
  // ----------------------------------------------------------------
  // Mode tracking
  // ----------------------------------------------------------------
  pba_pkg::pba_mode_e state_q;
  logic tgt_mode;
  logic ini_mode;
  logic tgt_xfer;
  logic ini_xfer;
  logic tgt_end;
  logic ini_end;

  assign tgt_mode = (state_q == pba_pkg::MODE_TGT);
  assign ini_mode = (state_q == pba_pkg::MODE_INI);
  assign tgt_xfer = tgt_mode && link.transfer_done_strobe;
  assign ini_xfer = ini_mode && link.transfer_done_strobe;
  assign tgt_end = tgt_mode && link.burst_end;
  assign ini_end = ini_mode && link.burst_end;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= pba_pkg::MODE_IDLE;
    end else begin
      case (state_q)
        pba_pkg::MODE_IDLE: begin
          if (ini_start) begin
            state_q <= pba_pkg::MODE_INI;
          end else if (link.address_phase_strobe) begin
            state_q <= pba_pkg::MODE_TGT;
          end
        end
        pba_pkg::MODE_TGT: begin
          if (link.burst_end) begin
            state_q <= pba_pkg::MODE_IDLE;
          end
        end
        pba_pkg::MODE_INI: begin
          if (link.burst_end) begin
            state_q <= pba_pkg::MODE_IDLE;
          end
        end
        default: begin
          state_q <= pba_pkg::MODE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_q <= pba_pkg::MODE_IDLE;
    end else begin
      mode_q <= state_q;
    end
  end

  // ----------------------------------------------------------------
  // Target address: upper register plus in-block counter
  // ----------------------------------------------------------------
  logic [TGT_W-1:0] tgt_cnt;
  logic [pba_pkg::TGT_UPPER_W-1:0] tgt_upper_q;
  logic blk_end_q;

  pba_ld_cnt #(
    .W(TGT_W)
  ) i_pba_ld_cnt_tgt (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(link.address_phase_strobe),
    .load_val(link.core_bus[pba_pkg::DW_LSB +: TGT_W]),
    .inc(tgt_xfer),
    .dec(1'b0),
    .count_q(tgt_cnt)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tgt_upper_q <= '0;
    end else if (link.address_phase_strobe) begin
      tgt_upper_q <= link.core_bus[pba_pkg::ADDR_W-1 -: pba_pkg::TGT_UPPER_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tgt_addr_q <= '0;
    end else begin
      tgt_addr_q <= pba_pkg::ADDR_W'({tgt_upper_q, tgt_cnt, 2'h0});
    end
  end

  // Last double word of the block reached: no further burst allowed
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      blk_end_q <= 1'b0;
    end else if (link.address_phase_strobe) begin
      blk_end_q <= 1'b0;
    end else if (tgt_mode && (tgt_cnt == '1)) begin
      blk_end_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Initiator address and termination handling
  // ----------------------------------------------------------------
  logic [INI_W-1:0] ini_cnt;
  logic [INI_W-1:0] ini_start_q;
  logic [INI_W-1:0] ini_load_val;
  logic ini_load;
  logic ini_retry;
  logic ini_disc;

  assign ini_retry = link.config_status_bus[pba_pkg::CSR_TERM_LSB + pba_pkg::TERM_RETRY];
  assign ini_disc = link.config_status_bus[pba_pkg::CSR_TERM_LSB + pba_pkg::TERM_DISC_DATA]
    || link.config_status_bus[pba_pkg::CSR_TERM_LSB + pba_pkg::TERM_DISC_NODATA];
  // Retry reload wins over the final step, so the restart is exact
  assign ini_load = ini_start || (ini_end && ini_retry);
  assign ini_load_val = ini_start ? ini_start_addr[pba_pkg::DW_LSB +: INI_W] : ini_start_q;

  pba_ld_cnt #(
    .W(INI_W)
  ) i_pba_ld_cnt_ini (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(ini_load),
    .load_val(ini_load_val),
    .inc(ini_xfer),
    .dec(1'b0),
    .count_q(ini_cnt)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ini_start_q <= '0;
    end else if (ini_start) begin
      ini_start_q <= ini_start_addr[pba_pkg::DW_LSB +: INI_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ini_addr_q <= '0;
    end else begin
      ini_addr_q <= pba_pkg::ADDR_W'({ini_cnt, 2'h0});
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ini_restart_q <= 1'b0;
    end else if (ini_start) begin
      ini_restart_q <= 1'b0;
    end else if (ini_end && ini_retry) begin
      ini_restart_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pipelined data source
  // ----------------------------------------------------------------
  logic [pba_pkg::DATA_W-1:0] src_mem [DEPTH];
  logic [pba_pkg::DATA_W-1:0] bus_q;
  logic [IDX_W-1:0] src_start_q;
  logic [IDX_W-1:0] src_ptr_d;
  logic src_back;

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      src_mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      src_start_q <= '0;
    end else if (ini_start) begin
      src_start_q <= src_start_idx;
    end
  end

  // The pointer runs one word ahead of the bus in a sourcing burst; step back at the end of a target read or a destructive disconnect
  assign src_back = (tgt_end && link.tgt_read)
    || (ini_end && destructive && ini_disc);

  // Target reads continue from the current pointer, as a FIFO would
  always_comb begin
    src_ptr_d = src_ptr_q;
    if (ini_start) begin
      src_ptr_d = src_start_idx;
    end else if (ini_end && destructive && ini_retry) begin
      src_ptr_d = src_start_q;
    end else if (link.source_advance_strobe && !src_back) begin
      src_ptr_d = src_ptr_q + IDX_W'(1);
    end else if (src_back && !link.source_advance_strobe) begin
      src_ptr_d = src_ptr_q - IDX_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      src_ptr_q <= '0;
    end else begin
      src_ptr_q <= src_ptr_d;
    end
  end

  // Word follows the pointer, so it holds still between advances
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_q <= pba_pkg::BUS_RST;
    end else begin
      bus_q <= src_mem[src_ptr_d];
    end
  end

  assign link.internal_shared_bus = bus_q;

  // ----------------------------------------------------------------
  // Ready and termination requests
  // ----------------------------------------------------------------
  logic ready_q;
  logic term_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
      term_q <= 1'b0;
    end else begin
      ready_q <= !stop_req || stop_with_data;
      term_q <= stop_req || blk_end_q;
    end
  end

  assign link.ready = ready_q;
  assign link.term = term_q;
endmodule

// ---- verilog/pba_core.sv ----
// Bus interface core end: transfer detection, source pipeline, status bus
`timescale 1ns/1ps
module pba_core (
  input wire logic sys_clk,
  input wire logic sys_rst,
  pba_link_if.core_mp link,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic tgt_addr_st,
  input wire logic tgt_data_st,
  input wire logic ini_addr_st,
  input wire logic ini_data_st,
  input wire logic tgt_is_read,
  input wire logic ini_is_write,
  input wire logic frame_end,
  input wire logic [pba_pkg::DATA_W-1:0] pci_ad_in,
  input wire logic [pba_pkg::TERM_W-1:0] term_status,
  input wire logic [pba_pkg::CSR_TERM_LSB-1:0] csr_low,
  output logic [pba_pkg::DATA_W-1:0] ad_out_q,
  output logic ready_out_q,
  output logic term_out_q
);
  // ----------------------------------------------------------------
  // Transfer detection and source advance
  // ----------------------------------------------------------------
  logic done_d;
  logic sourcing;
  logic adv_d;
  logic tgt_addr_q;
  logic ini_addr_q;
  logic done_q;
  logic adv_q;

  assign done_d = !irdy_n && !trdy_n && (tgt_data_st || ini_data_st);
  assign sourcing = (tgt_data_st && tgt_is_read) || (ini_data_st && ini_is_write);
  // First word on leaving the address state, then one per transfer that sources data
  assign adv_d = (ini_addr_q && !ini_addr_st && ini_is_write)
    || (tgt_addr_q && !tgt_addr_st && tgt_is_read)
    || (done_d && sourcing);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tgt_addr_q <= 1'b0;
      ini_addr_q <= 1'b0;
      done_q <= 1'b0;
      adv_q <= 1'b0;
    end else begin
      tgt_addr_q <= tgt_addr_st;
      ini_addr_q <= ini_addr_st;
      done_q <= done_d;
      adv_q <= adv_d;
    end
  end

  // ----------------------------------------------------------------
  // Output flip-flops
  // ----------------------------------------------------------------
  // Held between advances so the word on the pins stays stable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ad_out_q <= pba_pkg::BUS_RST;
    end else if (adv_d) begin
      ad_out_q <= link.internal_shared_bus;
    end
  end

  // ----------------------------------------------------------------
  // Address phase, status and handshake
  // ----------------------------------------------------------------
  logic addr_q;
  logic ini_phase_q;
  logic tgt_read_q;
  logic burst_end_q;
  logic [pba_pkg::DATA_W-1:0] core_bus_q;
  logic [pba_pkg::CSR_W-1:0] csr_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      addr_q <= 1'b0;
      ini_phase_q <= 1'b0;
      tgt_read_q <= 1'b0;
      burst_end_q <= 1'b0;
      core_bus_q <= pba_pkg::BUS_RST;
      csr_q <= pba_pkg::CSR_RST;
      ready_out_q <= 1'b0;
      term_out_q <= 1'b0;
    end else begin
      addr_q <= tgt_addr_st && !tgt_addr_q;
      ini_phase_q <= ini_addr_st;
      tgt_read_q <= tgt_is_read;
      burst_end_q <= frame_end && (tgt_data_st || ini_data_st);
      core_bus_q <= pci_ad_in;
      csr_q <= {term_status, csr_low};
      ready_out_q <= link.ready;
      term_out_q <= link.term;
    end
  end

  assign link.address_phase_strobe = addr_q;
  assign link.transfer_done_strobe = done_q;
  assign link.source_advance_strobe = adv_q;
  assign link.ini_addr_phase = ini_phase_q;
  assign link.tgt_read = tgt_read_q;
  assign link.burst_end = burst_end_q;
  assign link.core_bus = core_bus_q;
  assign link.config_status_bus = csr_q;
endmodule

// ---- verilog/pba_ld_cnt.sv ----
// Loadable up/down binary counter
`timescale 1ns/1ps
module pba_ld_cnt #(
  parameter int W = 10
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic inc,
  input wire logic dec,
  output logic [W-1:0] count_q
);
  // Load beats stepping; inc and dec together cancel
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (inc && !dec) begin
      count_q <= count_q + W'(1);
    end else if (dec && !inc) begin
      count_q <= count_q - W'(1);
    end
  end
endmodule

// ---- verilog/pba_link_if.sv ----
// Link between the bus interface core and the user application
`timescale 1ns/1ps
interface pba_link_if;
  logic address_phase_strobe;
  logic transfer_done_strobe;
  logic source_advance_strobe;
  logic ini_addr_phase;
  logic tgt_read;
  logic burst_end;
  logic [pba_pkg::DATA_W-1:0] core_bus;
  logic [pba_pkg::CSR_W-1:0] config_status_bus;
  logic [pba_pkg::DATA_W-1:0] internal_shared_bus;
  logic ready;
  logic term;

  modport core_mp (
    output address_phase_strobe,
    output transfer_done_strobe,
    output source_advance_strobe,
    output ini_addr_phase,
    output tgt_read,
    output burst_end,
    output core_bus,
    output config_status_bus,
    input internal_shared_bus,
    input ready,
    input term
  );

  modport app_mp (
    input address_phase_strobe,
    input transfer_done_strobe,
    input source_advance_strobe,
    input ini_addr_phase,
    input tgt_read,
    input burst_end,
    input core_bus,
    input config_status_bus,
    output internal_shared_bus,
    output ready,
    output term
  );
endinterface

// ---- verilog/pba_pkg.sv ----
// Shared constants and types for the burst address and source pipeline
package pba_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CSR_W = 40;
  localparam int DW_LSB = 2;
  localparam int TGT_CNT_W = 10;
  localparam int TGT_UPPER_W = 20;
  localparam int INI_CNT_W = 30;
  // ----------------------------------------------------------------
  // Termination status field in the top byte of the status bus
  // ----------------------------------------------------------------
  localparam int TERM_W = 8;
  localparam int CSR_TERM_LSB = 32;
  localparam int TERM_RETRY = 0;
  localparam int TERM_DISC_DATA = 1;
  localparam int TERM_DISC_NODATA = 2;
  // ----------------------------------------------------------------
  // Source store
  // ----------------------------------------------------------------
  localparam int SRC_DEPTH = 16;
  localparam int SRC_IDX_W = 4;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] BUS_RST = 32'h0000_0000;
  localparam logic [CSR_W-1:0] CSR_RST = 40'h00_0000_0000;
  // ----------------------------------------------------------------
  // Application transfer mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_TGT,
    MODE_INI
  } pba_mode_e;
endpackage
